/* radio_override_test_regs_bench.sv */
// Self-checking bench for the radio override and test register bank.
// Assumes the package and the far-side model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module radio_override_test_regs_bench
    import rotr_pkg::*;
;
    logic              clk = 1'b0, srst = 1'b1, load = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0]       paddr = 20'h0;
    logic [31:0]       pwdata = 32'h0, prdata;
    logic              pready, pslverr, adc_enable, adc_clk_en;
    logic [6:0]        agc_vga_gain, adc_i, adc_q, vga_gain;
    logic [1:0]        agc_gain_mode, frontend_gain_status;
    logic [5:0]        frame_ctrl_state;
    rotr_dac_inputs_s  dac_in;
    rotr_analog_ctrl_s analog_ctrl;
    rotr_iq_s          dac_out;
    // Expected register state
    logic [7:0]        m_oh;
    logic [6:0]        m_ol, m_gs;
    logic              m_ge, m_ad;
    logic [1:0]        m_gf;
    logic [2:0]        m_ds;
    logic [5:0]        m_di, m_dq;
    // Far-side values presented and offered
    logic [89:0]       env, nxt = 90'h0;
    integer            seed = 32'hD8072C3D;
    int                fails = 0, samples_checked = 0;
    logic [15:0]       regs [9] = '{IDX_OVR_HIGH, IDX_OVR_LOW, IDX_GAIN_HIGH, IDX_GAIN_LOW,
        IDX_FSM_STATE, IDX_ADC_HIGH, IDX_ADC_LOW, IDX_DAC_HIGH, IDX_DAC_LOW};
    // Unmapped index, misaligned byte, upper address bits set
    logic [19:0]       bad [3] = '{20'h37CA0, 20'h37C91, 20'h77C94};

    always #20 clk = ~clk;

    rotr_regs i_rotr_regs (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .agc_vga_gain(agc_vga_gain), .agc_gain_mode(agc_gain_mode),
        .frame_ctrl_state(frame_ctrl_state), .adc_i(adc_i), .adc_q(adc_q),
        .adc_enable(adc_enable), .dac_in(dac_in), .analog_ctrl(analog_ctrl),
        .vga_gain(vga_gain), .frontend_gain_status(frontend_gain_status),
        .adc_clk_en(adc_clk_en), .dac_out(dac_out));
    rotr_fe_model i_rotr_fe_model (
        .clk(clk), .srst(srst), .load(load), .nxt(nxt), .adc_clk_en(adc_clk_en),
        .agc_vga_gain(agc_vga_gain), .agc_gain_mode(agc_gain_mode),
        .frame_ctrl_state(frame_ctrl_state), .adc_enable(adc_enable), .adc_i(adc_i),
        .adc_q(adc_q), .dac_in(dac_in));

    // Gain actually applied: manual value only while override is on
    function automatic logic [6:0] f_gain();
        return m_ge ? m_gs : env[89:83];
    endfunction : f_gain

    // Gain mode in use: automatic choice unless forced
    function automatic logic [1:0] f_mode();
        return (m_gf == 2'h0) ? env[82:81] : m_gf;
    endfunction : f_mode

    // Converter data chosen by the source selector
    function automatic rotr_iq_s f_dac();
        rotr_dac_inputs_s d;
        logic [6:0]       ai;
        logic [6:0]       aq;
        d = env[59:0];
        ai = env[73:67];
        aq = env[66:60];
        case (m_ds)
            3'h0: return d.modulator;
            3'h1: return {m_di, m_dq};
            3'h2: return {ai[6:1], aq[6:1]};
            3'h3: return d.downmix;
            3'h4: return d.noise;
            3'h5: return {ai[5:0], aq[5:0]};
            3'h6: return d.magnitude;
            default: return d.debug;
        endcase
    endfunction : f_dac

    // Read value of each register; reserved bits read zero
    function automatic logic [31:0] f_rd(input logic [15:0] i);
        case (i)
            IDX_OVR_HIGH: return {24'h0, m_oh};
            IDX_OVR_LOW: return {25'h0, m_ol};
            IDX_GAIN_HIGH: return {24'h0, m_ge, f_gain()};
            IDX_GAIN_LOW: return {28'h0, m_gf, f_mode()};
            IDX_FSM_STATE: return {26'h0, env[80:75]};
            IDX_ADC_HIGH: return {24'h0, m_ad, env[73:67]};
            IDX_ADC_LOW: return {25'h0, env[66:60]};
            IDX_DAC_HIGH: return {25'h0, m_ds, m_di[5:2]};
            IDX_DAC_LOW: return {24'h0, m_di[1:0], m_dq};
            default: return 32'h0;
        endcase
    endfunction : f_rd

    // Writable fields only; read-only places keep their state
    function automatic void upd(input logic [15:0] i, input logic [7:0] d);
        case (i)
            IDX_OVR_HIGH: m_oh = d;
            IDX_OVR_LOW: m_ol = d[6:0];
            IDX_GAIN_HIGH: {m_ge, m_gs} = d;
            IDX_GAIN_LOW: m_gf = d[3:2];
            IDX_ADC_HIGH: m_ad = d[7];
            IDX_DAC_HIGH: {m_ds, m_di[5:2]} = d[6:0];
            IDX_DAC_LOW: {m_di[1:0], m_dq} = d;
            default: ;
        endcase
    endfunction : upd

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; waits for pready under a bounded count
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fails++;
        end
    endtask : apb

    // Register write with junk in the unused upper data bits
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        logic [31:0] rd;
        logic        er;
        logic [31:0] rv;
        rv = $random(seed);
        apb(1'b1, {2'b00, i, 2'b00}, {rv[31:8], d}, rd, er);
        chk("write err", {31'h0, er}, 32'h0);
        upd(i, d);
    endtask : wr

    // New far-side values; samples only move while the converter is clocked
    task automatic new_env();
        logic [89:0] r;
        logic        gate;
        r = {26'($random(seed)), 32'($random(seed)), 32'($random(seed))};
        gate = env[74] & ~m_ad;
        @(posedge clk);
        nxt <= r;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        env[89:74] = r[89:74];
        env[59:0] = r[59:0];
        if (gate) begin
            env[73:60] = r[73:60];
        end
    endtask : new_env

    // Outputs after settling, then every register read back
    task automatic check_all();
        logic [31:0] rd;
        logic        er;
        repeat (2) @(posedge clk);
        #1;
        chk("analog_ctrl", {16'h0, analog_ctrl}, {16'h0, m_oh, m_oh[2] & m_oh[1], m_ol});
        chk("vga_gain", {25'h0, vga_gain}, {25'h0, f_gain()});
        chk("gain_status", {30'h0, frontend_gain_status}, {30'h0, f_mode()});
        chk("adc_clk_en", {31'h0, adc_clk_en}, {31'h0, env[74] & ~m_ad});
        chk("dac_out", {20'h0, dac_out}, {20'h0, f_dac()});
        foreach (regs[k]) begin
            apb(1'b0, {2'b00, regs[k], 2'b00}, 32'h0, rd, er);
            chk($sformatf("read %h", regs[k]), rd, f_rd(regs[k]));
            chk("read err", {31'h0, er}, 32'h0);
        end
    endtask : check_all

    task automatic do_reset();
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("vga_gain in reset", {25'h0, vga_gain}, 32'h7F);
        chk("analog in reset", {16'h0, analog_ctrl}, 32'h0);
        @(posedge clk);
        srst <= 1'b0;
        {m_oh, m_ol, m_ge, m_gs, m_gf, m_ad} = {8'h00, 7'h00, 1'b0, 7'h7F, 2'h0, 1'b0};
        {m_ds, m_di, m_dq} = 15'h0;
        env = nxt;
    endtask : do_reset

    task automatic stop_test();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial begin
        logic [31:0] rv;
        logic [31:0] rd;
        logic        er;
        do_reset();
        check_all();
        // Every source and force code, reserved bits written as ones
        for (int k = 0; k < 8; k++) begin
            wr(IDX_OVR_HIGH, 8'h00);
            wr(IDX_DAC_HIGH, {1'b1, 3'(k), 4'hA});
            wr(IDX_GAIN_LOW, {4'hF, 2'(k), 2'h3});
            new_env();
            check_all();
        end
        // Refused addresses: error, zero data, no state change
        foreach (bad[k]) begin
            apb(1'b1, bad[k], 32'hFFFFFFFF, rd, er);
            chk("bad write err", {31'h0, er}, 32'h1);
            apb(1'b0, bad[k], 32'h0, rd, er);
            chk("bad read err", {31'h0, er}, 32'h1);
            chk("bad read data", rd, 32'h0);
        end
        check_all();
        // Random writes, including read-only places, with moving inputs
        for (int n = 0; n < 150; n++) begin
            rv = $random(seed);
            wr(regs[rv[7:0] % 9], rv[15:8]);
            if (rv[20]) begin
                new_env();
            end
            if (rv[21] || rv[22]) begin
                check_all();
            end
        end
        // Reset in mid-run restores every field
        do_reset();
        check_all();
        stop_test();
    end
endmodule : radio_override_test_regs_bench

`default_nettype wire

/* rotr_fe_model.sv */
// Far-side model: radio front end and datapath status toward the bank.
// Assumes the bench offers new values with a one-cycle load strobe.
`timescale 1ns/1ns
`default_nettype none

module rotr_fe_model
    import rotr_pkg::*;
(
    // Clock, reset and load request
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             load,
    // Offered gain, mode, state, enable, I, Q, converter data
    input  wire logic [89:0]      nxt,
    // Converter clock gate from the bank
    input  wire logic             adc_clk_en,
    // Toward the bank
    output var  logic [6:0]       agc_vga_gain,
    output var  logic [1:0]       agc_gain_mode,
    output var  logic [5:0]       frame_ctrl_state,
    output var  logic             adc_enable,
    output var  logic [6:0]       adc_i,
    output var  logic [6:0]       adc_q,
    output var  rotr_dac_inputs_s dac_in
);
    logic [15:0] sts_q; // Gain, mode, state, enable
    logic [13:0] smp_q; // Last converted I and Q
    logic [59:0] dat_q; // Datapath candidates

    // Offered values show through in reset, so no input starts unknown
    always_comb begin
        {agc_vga_gain, agc_gain_mode, frame_ctrl_state, adc_enable} = srst ? nxt[89:74] : sts_q;
        {adc_i, adc_q} = srst ? nxt[73:60] : smp_q;
        dac_in = srst ? nxt[59:0] : dat_q;
    end

    // Status and datapath follow the load strobe
    always_ff @(posedge clk) begin
        if (srst || load) begin
            sts_q <= nxt[89:74];
            dat_q <= nxt[59:0];
        end
    end

    // stopped converter clock
    // Without a clock the converter keeps its last sample
    always_ff @(posedge clk) begin
        if (srst || (load && adc_clk_en)) begin
            smp_q <= nxt[73:60];
        end
    end
endmodule : rotr_fe_model

`default_nettype wire

/* rotr_pkg.sv */
// Constants, field layouts and carrier types for the radio override/test registers.
// Assumes a 32-bit APB slave on the system clock; registers are eight bits wide.
// Operation
// - Gain override bit applies manual amplifier gain
// - Gain resets 7F; read returns applied gain
// - Front-end gain force: auto, low, medium, high
// - Status shows front-end gain mode in use
// - Frame-control state readable; upper bits zero
// - Clock-disable bit stops the receive ADC clock
// - ADC high register returns in-phase sample
// - ADC low register returns quadrature sample
// - DAC source: modulator, ADC high, down-mix, ADC low
// - Source 001 drives DACs from override values
// - DAC source: noise, magnitude, debug port
// - I override split across two DAC registers
// - Q override in low six bits, reset zero
// - High bit 7 drives peak detector reset
// - High bit 6 powers down global bias
// - High bit 5 drives external bias switch
// - High bit 4 selects oscillator or amplifier buffers
// - High bits 3..0 power down transmit blocks
// - Both amplifier paths down powers down up-mixers
// - Low register bits 6..0 power down receive blocks

package rotr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_OVR_HIGH   = 16'hDF24;
    localparam logic [15:0] IDX_OVR_LOW    = 16'hDF25;
    localparam logic [15:0] IDX_GAIN_HIGH  = 16'hDF26;
    localparam logic [15:0] IDX_GAIN_LOW   = 16'hDF27;
    localparam logic [15:0] IDX_FSM_STATE  = 16'hDF39;
    localparam logic [15:0] IDX_ADC_HIGH   = 16'hDF3A;
    localparam logic [15:0] IDX_ADC_LOW    = 16'hDF3B;
    localparam logic [15:0] IDX_DAC_HIGH   = 16'hDF3C;
    localparam logic [15:0] IDX_DAC_LOW    = 16'hDF3D;

    // Reset values
    localparam logic [7:0] RST_OVR_HIGH  = 8'h00;
    localparam logic [7:0] RST_OVR_LOW   = 8'h00;
    localparam logic [6:0] RST_VGA_GAIN  = 7'h7F;
    localparam logic [5:0] RST_DAC_VAL   = 6'h00;
    localparam logic [2:0] RST_TX_CONVERTER_SOURCE   = 3'h0;

    // Field masks of writable bits per register
    localparam logic [7:0] MSK_OVR_LOW   = 8'h7F;
    localparam logic [7:0] MSK_GAIN_LOW  = 8'h0C;
    localparam logic [7:0] MSK_ADC_HIGH  = 8'h80;
    localparam logic [7:0] MSK_DAC_HIGH  = 8'h7F;

    // Front-end gain force codes
    typedef enum logic [1:0] {
        GF_AUTO = 2'h0,
        GF_LOW  = 2'h1,
        GF_MED  = 2'h2,
        GF_HIGH = 2'h3
    } rotr_gain_force_e;

    // Transmit converter source codes
    typedef enum logic [2:0] {
        DS_MODULATOR = 3'h0,
        DS_OVERRIDE  = 3'h1,
        DS_ADC_MSB   = 3'h2,
        DS_DOWNMIX   = 3'h3,
        DS_NOISE     = 3'h4,
        DS_ADC_LSB   = 3'h5,
        DS_MAGNITUDE = 3'h6,
        DS_DEBUG     = 3'h7
    } rotr_tx_converter_source_e;

    // One I/Q pair for the transmit converters
    typedef struct packed {
        logic [5:0] i;
        logic [5:0] q;
    } rotr_iq_s;

    // Candidate converter data from the datapath
    typedef struct packed {
        rotr_iq_s modulator;
        rotr_iq_s downmix;
        rotr_iq_s noise;
        rotr_iq_s magnitude;
        rotr_iq_s debug;
    } rotr_dac_inputs_s;

    // Analog control lines toward the front end
    typedef struct packed {
        logic peak_det_rst_n;
        logic global_bias_powerdown;
        logic pa_external_bias_switch;
        logic pa_buffer_select;
        logic prescaler_powerdown;
        logic pa_negative_powerdown;
        logic pa_positive_powerdown;
        logic tx_dac_powerdown;
        logic upmix_powerdown;
        logic filter_cal_osc_powerdown;
        logic charge_pump_powerdown;
        logic synth_chain_powerdown;
        logic rx_adc_powerdown;
        logic gain_amp_powerdown;
        logic bandpass_filter_powerdown;
        logic frontend_powerdown;
    } rotr_analog_ctrl_s;

endpackage : rotr_pkg

/* rotr_regs.sv */
// Override and test register bank of the radio front end, APB slave.
// Assumes APB master on clk; gain, ADC and state inputs are synchronous.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module rotr_regs
    import rotr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,

    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [19:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,

    // Receive side status
    input  wire logic [6:0]        agc_vga_gain,
    input  wire logic [1:0]        agc_gain_mode,
    input  wire logic [5:0]        frame_ctrl_state,
    input  wire logic [6:0]        adc_i,
    input  wire logic [6:0]        adc_q,
    input  wire logic              adc_enable,

    // Transmit datapath candidates
    input  wire rotr_dac_inputs_s  dac_in,

    // Front-end controls
    output var  rotr_analog_ctrl_s analog_ctrl,
    output var  logic [6:0]        vga_gain,
    output var  logic [1:0]        frontend_gain_status,
    output var  logic              adc_clk_en,
    output var  rotr_iq_s          dac_out
);

    // Stored register fields
    logic [7:0]    ovr_high_q;      // Transmit-side overrides
    logic [6:0]    ovr_low_q;       // Receive-side powerdowns
    logic          vga_oe_q;        // Manual gain in use
    logic [6:0]    vga_manual_q;    // Written manual gain
    logic [1:0]    gain_force_q;    // Front-end gain force code
    logic          adc_clk_dis_q;   // ADC clock stop
    logic [2:0]    tx_converter_source_q;       // Converter source select
    logic [5:0]    dac_i_ovr_q;     // I override value
    logic [5:0]    dac_q_ovr_q;     // Q override value

    // Bus decode
    logic [15:0]   idx;             // Word index of access
    logic          wr_en;           // Write completes this edge
    logic          mapped;          // Address hits a register
    logic [7:0]    rd_byte;         // Read mux result

    assign idx     = paddr[17:2];
    assign wr_en   = psel & penable & pwrite & mapped;

    // Zero-wait slave: data was latched in setup, so answer at once
    assign pready  = 1'b1;

    // Unmapped access reports error in access phase
    always_comb begin
        unique case (idx)
            IDX_OVR_HIGH,
            IDX_OVR_LOW,
            IDX_GAIN_HIGH,
            IDX_GAIN_LOW,
            IDX_FSM_STATE,
            IDX_ADC_HIGH,
            IDX_ADC_LOW,
            IDX_DAC_HIGH,
            IDX_DAC_LOW:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
        if (paddr[19:18] != 2'h0 || paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end
    end

    assign pslverr = psel & penable & ~mapped;

    // Read mux; reserved bits come back as zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            IDX_OVR_HIGH:  rd_byte = ovr_high_q;
            IDX_OVR_LOW:   rd_byte = {1'b0, ovr_low_q};
            IDX_GAIN_HIGH: rd_byte = {vga_oe_q, vga_gain};
            IDX_GAIN_LOW:  rd_byte = {4'h0, gain_force_q, frontend_gain_status};
            IDX_FSM_STATE: rd_byte = {2'h0, frame_ctrl_state};
            IDX_ADC_HIGH:  rd_byte = {adc_clk_dis_q, adc_i};
            IDX_ADC_LOW:   rd_byte = {1'b0, adc_q};
            IDX_DAC_HIGH:  rd_byte = {1'b0, tx_converter_source_q, dac_i_ovr_q[5:2]};
            IDX_DAC_LOW:   rd_byte = {dac_i_ovr_q[1:0], dac_q_ovr_q};
            default:       rd_byte = 8'h00;
        endcase
    end

    // Read data captured in the setup cycle and held through access
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Override register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            ovr_high_q <= RST_OVR_HIGH;
            ovr_low_q  <= RST_OVR_LOW[6:0];
        end else if (wr_en) begin
            if (idx == IDX_OVR_HIGH) begin
                ovr_high_q <= pwdata[7:0];
            end
            if (idx == IDX_OVR_LOW) begin
                ovr_low_q <= pwdata[6:0] & MSK_OVR_LOW[6:0];
            end
        end
    end

    // Gain control register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            vga_oe_q     <= 1'b0;
            vga_manual_q <= RST_VGA_GAIN;
            gain_force_q <= GF_AUTO;
        end else if (wr_en) begin
            if (idx == IDX_GAIN_HIGH) begin
                vga_oe_q     <= pwdata[7];
                vga_manual_q <= pwdata[6:0];
            end
            if (idx == IDX_GAIN_LOW) begin
                gain_force_q <= pwdata[3:2] & MSK_GAIN_LOW[3:2];
            end
        end
    end

    // Test register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            adc_clk_dis_q <= 1'b0;
            tx_converter_source_q     <= RST_TX_CONVERTER_SOURCE;
            dac_i_ovr_q   <= RST_DAC_VAL;
            dac_q_ovr_q   <= RST_DAC_VAL;
        end else if (wr_en) begin
            if (idx == IDX_ADC_HIGH) begin
                adc_clk_dis_q <= pwdata[7] & MSK_ADC_HIGH[7];
            end
            if (idx == IDX_DAC_HIGH) begin
                tx_converter_source_q         <= pwdata[6:4] & MSK_DAC_HIGH[6:4];
                dac_i_ovr_q[5:2]  <= pwdata[3:0];
            end
            // Q value and I low bits
            if (idx == IDX_DAC_LOW) begin
                dac_i_ovr_q[1:0]  <= pwdata[7:6];
                dac_q_ovr_q       <= pwdata[5:0];
            end
        end
    end

    // Applied gain and gain mode, registered toward the front end
    always_ff @(posedge clk) begin
        if (srst) begin
            vga_gain             <= RST_VGA_GAIN;
            frontend_gain_status <= GF_AUTO;
        end else begin
            vga_gain <= vga_oe_q ? vga_manual_q : agc_vga_gain;
            unique case (rotr_gain_force_e'(gain_force_q))
                GF_AUTO: frontend_gain_status <= agc_gain_mode;
                GF_LOW:  frontend_gain_status <= GF_LOW;
                GF_MED:  frontend_gain_status <= GF_MED;
                GF_HIGH: frontend_gain_status <= GF_HIGH;
            endcase
        end
    end

    // ADC clock gate; stays off under reset
    always_ff @(posedge clk) begin
        if (srst) begin
            adc_clk_en <= 1'b0;
        end else begin
            adc_clk_en <= adc_enable & ~adc_clk_dis_q;
        end
    end

    // Analog control lines, one flop per line to avoid glitches
    always_ff @(posedge clk) begin
        if (srst) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.peak_det_rst_n          <= ovr_high_q[7];
            analog_ctrl.global_bias_powerdown   <= ovr_high_q[6];
            analog_ctrl.pa_external_bias_switch <= ovr_high_q[5];
            analog_ctrl.pa_buffer_select        <= ovr_high_q[4];
            analog_ctrl.prescaler_powerdown     <= ovr_high_q[3];
            analog_ctrl.pa_negative_powerdown   <= ovr_high_q[2];
            analog_ctrl.pa_positive_powerdown   <= ovr_high_q[1];
            analog_ctrl.tx_dac_powerdown        <= ovr_high_q[0];
            analog_ctrl.upmix_powerdown         <= ovr_high_q[2] & ovr_high_q[1];
            analog_ctrl.filter_cal_osc_powerdown  <= ovr_low_q[6];
            analog_ctrl.charge_pump_powerdown     <= ovr_low_q[5];
            analog_ctrl.synth_chain_powerdown     <= ovr_low_q[4];
            analog_ctrl.rx_adc_powerdown          <= ovr_low_q[3];
            analog_ctrl.gain_amp_powerdown        <= ovr_low_q[2];
            analog_ctrl.bandpass_filter_powerdown <= ovr_low_q[1];
            analog_ctrl.frontend_powerdown        <= ovr_low_q[0];
        end
    end

    // Converter source mux; software must power DACs up itself
    always_ff @(posedge clk) begin
        if (srst) begin
            dac_out <= '0;
        end else begin
            unique case (rotr_tx_converter_source_e'(tx_converter_source_q))
                DS_MODULATOR: dac_out <= dac_in.modulator;
                DS_ADC_MSB:   dac_out <= '{i: adc_i[6:1], q: adc_q[6:1]};
                DS_DOWNMIX:   dac_out <= dac_in.downmix;
                DS_ADC_LSB:   dac_out <= '{i: adc_i[5:0], q: adc_q[5:0]};
                DS_OVERRIDE:  dac_out <= '{i: dac_i_ovr_q, q: dac_q_ovr_q};
                DS_NOISE:     dac_out <= dac_in.noise;
                DS_MAGNITUDE: dac_out <= dac_in.magnitude;
                DS_DEBUG:     dac_out <= dac_in.debug;
            endcase
        end
    end

    // Checks on the bank's own outputs and stored fields
    property p_vga_override;
        @(posedge clk) disable iff (srst)
        vga_oe_q |=> vga_gain == $past(vga_manual_q);
    endproperty
    a_vga_override: assert property (p_vga_override)
        else $error("manual gain not applied");

    property p_vga_auto;
        @(posedge clk) disable iff (srst)
        !vga_oe_q |=> vga_gain == $past(agc_vga_gain);
    endproperty
    a_vga_auto: assert property (p_vga_auto)
        else $error("automatic gain not applied");

    property p_gain_force;
        @(posedge clk) disable iff (srst)
        gain_force_q != GF_AUTO |=> frontend_gain_status == $past(gain_force_q);
    endproperty
    a_gain_force: assert property (p_gain_force)
        else $error("forced gain mode not in use");

    property p_adc_gate;
        @(posedge clk) disable iff (srst)
        adc_clk_dis_q ##1 adc_clk_dis_q |-> !adc_clk_en;
    endproperty
    a_adc_gate: assert property (p_adc_gate)
        else $error("ADC clock running while disabled");

    property p_dac_override;
        @(posedge clk) disable iff (srst)
        tx_converter_source_q == DS_OVERRIDE |=> dac_out.i == $past(dac_i_ovr_q)
            && dac_out.q == $past(dac_q_ovr_q);
    endproperty
    a_dac_override: assert property (p_dac_override)
        else $error("DAC override values not driven");

    property p_dac_adc_msb;
        @(posedge clk) disable iff (srst)
        tx_converter_source_q == DS_ADC_MSB |=> dac_out.i == $past(adc_i[6:1]);
    endproperty
    a_dac_adc_msb: assert property (p_dac_adc_msb)
        else $error("ADC high bits not routed");

    property p_upmix;
        @(posedge clk) disable iff (srst)
        1'b1 |=> analog_ctrl.upmix_powerdown
            == ($past(ovr_high_q[2]) && $past(ovr_high_q[1]));
    endproperty
    a_upmix: assert property (p_upmix)
        else $error("up-mixers down without both amplifier paths down");

    sequence s_ovr_high_wr;
        wr_en && idx == IDX_OVR_HIGH;
    endsequence

    property p_bias_write;
        @(posedge clk) disable iff (srst)
        s_ovr_high_wr ##1 !(wr_en && idx == IDX_OVR_HIGH)
            |=> analog_ctrl.global_bias_powerdown == $past(pwdata[6], 2);
    endproperty
    a_bias_write: assert property (p_bias_write)
        else $error("global bias powerdown not following write");

    property p_reserved_low;
        @(posedge clk) disable iff (srst)
        psel && !penable && !pwrite && idx == IDX_OVR_LOW |=> prdata[7:0] < 8'h80;
    endproperty
    a_reserved_low: assert property (p_reserved_low)
        else $error("reserved bit reads nonzero");

    property p_refused_write;
        @(posedge clk) disable iff (srst)
        psel && penable && pwrite && !mapped
            |=> $stable(ovr_high_q) && $stable(ovr_low_q)
            && $stable(vga_manual_q) && $stable(gain_force_q)
            && $stable(tx_converter_source_q);
    endproperty
    a_refused_write: assert property (p_refused_write)
        else $error("refused write changed a field");

    property p_fsm_read;
        @(posedge clk) disable iff (srst)
        psel && !penable && !pwrite && mapped && idx == IDX_FSM_STATE
            |=> prdata == {26'h0, $past(frame_ctrl_state)};
    endproperty
    a_fsm_read: assert property (p_fsm_read)
        else $error("frame state read wrong");

    property p_adc_low_read;
        @(posedge clk) disable iff (srst)
        psel && !penable && !pwrite && mapped && idx == IDX_ADC_LOW
            |=> prdata == {25'h0, $past(adc_q)};
    endproperty
    a_adc_low_read: assert property (p_adc_low_read)
        else $error("quadrature read wrong");

    property p_rx_powerdown;
        @(posedge clk) disable iff (srst)
        1'b1 |=> analog_ctrl.frontend_powerdown == $past(ovr_low_q[0])
            && analog_ctrl.filter_cal_osc_powerdown == $past(ovr_low_q[6]);
    endproperty
    a_rx_powerdown: assert property (p_rx_powerdown)
        else $error("receive powerdown wrong");

    property p_peak_det;
        @(posedge clk) disable iff (srst)
        1'b1 |=> analog_ctrl.peak_det_rst_n == $past(ovr_high_q[7]);
    endproperty
    a_peak_det: assert property (p_peak_det)
        else $error("peak detector reset wrong");

endmodule : rotr_regs

`default_nettype wire
